// [rtl/i2c_ssc.sv]
// I2C master Start generation with Start and Stop bus collision detection.
// Assumes open-drain SDA/SCL resolved outside, and a plain register port on i_mclk.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ssc_defs.svh"

module i2c_ssc
  import i2c_ssc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire reg_req_t   i_req,
  output var  logic [7:0] o_rdata,
  input  wire logic       i_sda,
  input  wire logic       i_scl,
  output var  line_out_t  o_line,
  output var  logic       o_irq
);

  engine_t s_reg;
  engine_t s_next;

  logic                   sda_hi;
  logic                   scl_hi;
  logic                   expired;
  logic                   busy;
  logic [`ST_W-1:0]       set_ev;
  logic [`ST_W-1:0]       clr_ev;

  assign sda_hi  = s_reg.sda_lv;
  assign scl_hi  = s_reg.scl_lv;
  assign expired = (s_reg.cnt == 8'h00);
  assign busy    = (s_reg.state != ST_IDLE) && (s_reg.state != ST_OWNED);

  always_comb begin
    s_next = s_reg;
    set_ev = '0;
    clr_ev = '0;

    // Three-stage synchronisers; a level is taken once stages two and three agree.
    s_next.sda_sync = {s_reg.sda_sync[1:0], i_sda};
    s_next.scl_sync = {s_reg.scl_sync[1:0], i_scl};
    if (s_reg.sda_sync[1] == s_reg.sda_sync[2]) begin
      s_next.sda_lv = s_reg.sda_sync[2];
    end
    if (s_reg.scl_sync[1] == s_reg.scl_sync[2]) begin
      s_next.scl_lv = s_reg.scl_sync[2];
    end

    // The baud counter runs down to zero and rests there until a phase reloads it.
    if (!expired) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end

    // Every bus phase except the wait for SCL high in ST_STOP_SCL_WAIT is timed by the baud counter.
    // A collision abandons the sequence, releases both lines and goes idle, so software meets a clean engine.
    case (s_reg.state)
      ST_IDLE: begin
        s_next.line = '0;
        if (s_reg.ctrl[`CTRL_START_BIT]) begin
          if (sda_hi && scl_hi) begin
            s_next.cnt   = s_reg.reload;                                   // RULE2
            s_next.state = ST_START_WAIT;                                  // RULE1
          end else if (!sda_hi && !scl_hi) begin
            set_ev[`ST_BCOL_BIT]          = 1'b1;                          // RULE5
            s_next.ctrl[`CTRL_START_BIT]  = 1'b0;
          end
        end
      end
      ST_START_WAIT: begin
        if (!scl_hi || (expired && !sda_hi)) begin
          set_ev[`ST_BCOL_BIT]         = 1'b1;                             // RULE5
          s_next.ctrl[`CTRL_START_BIT] = 1'b0;
          s_next.state                 = ST_IDLE;
        end else if (expired) begin
          s_next.line.sda_oe    = 1'b1;                                    // RULE3
          s_next.start_bit      = 1'b1;
          set_ev[`ST_START_BIT] = 1'b1;
          s_next.cnt            = s_reg.reload;                            // RULE4
          s_next.state          = ST_START_HOLD;
        end
      end
      ST_START_HOLD: begin
        if (expired) begin
          s_next.ctrl[`CTRL_START_BIT] = 1'b0;                             // RULE4
          s_next.state                 = ST_OWNED;
        end
      end
      ST_OWNED: begin
        if (s_reg.ctrl[`CTRL_STOP_BIT]) begin
          s_next.line.sda_oe = 1'b1;                                       // RULE6
          s_next.line.scl_oe = 1'b1;
          s_next.cnt         = s_reg.reload;
          s_next.state       = ST_STOP_PREP;
        end
      end
      ST_STOP_PREP: begin
        if (expired && !sda_hi) begin
          s_next.line.scl_oe = 1'b0;                                       // RULE6
          s_next.state       = ST_STOP_SCL_WAIT;
        end
      end
      ST_STOP_SCL_WAIT: begin
        if (scl_hi) begin
          s_next.cnt   = s_reg.reload;                                     // RULE7
          s_next.state = ST_STOP_SCL_HIGH;
        end else begin
          s_next.cnt = s_reg.cnt;
        end
      end
      ST_STOP_SCL_HIGH: begin
        if (!scl_hi) begin
          set_ev[`ST_BCOL_BIT] = 1'b1;                                     // RULE9
          s_next.line          = '0;                                       // RULE10
          s_next.ctrl[`CTRL_STOP_BIT] = 1'b0;
          s_next.start_bit     = 1'b0;
          s_next.state         = ST_IDLE;
        end else if (expired) begin
          s_next.line.sda_oe = 1'b0;
          s_next.cnt         = s_reg.reload;
          s_next.state       = ST_STOP_SDA_CHK;
        end
      end
      ST_STOP_SDA_CHK: begin
        if (expired) begin
          if (!sda_hi) begin
            set_ev[`ST_BCOL_BIT] = 1'b1;                                   // RULE8
          end else begin
            set_ev[`ST_STOP_BIT] = 1'b1;
          end
          s_next.line                 = '0;                                // RULE10
          s_next.ctrl[`CTRL_STOP_BIT] = 1'b0;
          s_next.start_bit            = 1'b0;
          s_next.state                = ST_IDLE;
        end
      end
      default: begin
        s_next.line  = '0;
        s_next.state = ST_IDLE;
      end
    endcase

    // Register writes; a control write is dropped while the Start bit is set, but can override a hardware clear of the Stop bit.
    if (i_req.wr) begin
      case (i_req.addr)
        `ADDR_SEQ_CTRL: begin
          if (!s_reg.ctrl[`CTRL_START_BIT]) begin
            s_next.ctrl = i_req.wdata[`CTRL_SEQ_W-1:0];                    // RULE12
          end
        end
        `ADDR_BAUD:   s_next.reload = i_req.wdata;
        `ADDR_CLEAR:  clr_ev = i_req.wdata[`ST_W-1:0];
        `ADDR_INT_EN: s_next.int_en = i_req.wdata[`ST_W-1:0];
        `ADDR_BUFFER: begin
          if (busy) begin
            set_ev[`ST_WRITE_COLLISION_FLAG_BIT] = 1'b1;                                   // RULE11
          end else begin
            s_next.buffer = i_req.wdata;
          end
        end
        default: ;
      endcase
    end

    // Set wins over clear on every sticky status bit.
    s_next.status = (s_reg.status & ~clr_ev) | set_ev;
    s_next.irq    = |(s_reg.status & s_reg.int_en);

    s_next.rdata = 8'h00;
    if (i_req.rd) begin
      case (i_req.addr)
        `ADDR_SEQ_CTRL:  s_next.rdata = {3'b000, s_reg.ctrl};
        `ADDR_BAUD:      s_next.rdata = s_reg.reload;
        `ADDR_STATUS:    s_next.rdata = {4'h0, s_reg.status};
        `ADDR_INT_EN:    s_next.rdata = {4'h0, s_reg.int_en};
        `ADDR_BUFFER:    s_next.rdata = s_reg.buffer;
        `ADDR_PORT_STAT: s_next.rdata = {4'h0, busy, s_reg.start_bit, scl_hi, sda_hi};
        default:         s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_reg          <= '0;
      s_reg.sda_sync <= 3'b111;
      s_reg.scl_sync <= 3'b111;
      s_reg.sda_lv   <= 1'b1;
      s_reg.scl_lv   <= 1'b1;
      s_reg.state    <= ST_IDLE;
      s_reg.reload   <= `BAUD_RESET;
      s_reg.ctrl     <= `CTRL_RESET;
      s_reg.status   <= `ST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_line  = s_reg.line;
  assign o_irq   = s_reg.irq;

  // Checks run on the engine's own clock and stay quiet while reset is high.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence start_armed_s;
    s_reg.state == ST_IDLE && s_reg.ctrl[`CTRL_START_BIT] && sda_hi && scl_hi;
  endsequence

  sequence start_fires_s;
    s_reg.state == ST_START_WAIT && expired && sda_hi && scl_hi;
  endsequence

  sequence hold_expires_s;
    s_reg.state == ST_START_HOLD && expired;
  endsequence

  sequence start_blocked_s;
    s_reg.state == ST_IDLE && s_reg.ctrl[`CTRL_START_BIT] && !sda_hi && !scl_hi;
  endsequence

  start_go_a: assert property (start_armed_s |=> s_reg.state == ST_START_WAIT) // RULE1
    else $error("Start not begun after start_enable.");
  reload_a: assert property (start_armed_s |=> s_reg.cnt == $past(s_reg.reload)) // RULE2
    else $error("Baud counter not loaded at Start.");
  start_drive_a: assert property (start_fires_s |=> s_reg.line.sda_oe && s_reg.status[`ST_START_BIT]) // RULE3
    else $error("SDA not driven low at baud expiry.");
  hold_reload_a: assert property (start_fires_s |=> // RULE4
    s_reg.state == ST_START_HOLD && s_reg.cnt == $past(s_reg.reload))
    else $error("Baud counter not reloaded after SDA went low.");
  start_done_a: assert property (hold_expires_s |=> // RULE4
    !s_reg.ctrl[`CTRL_START_BIT] && s_reg.state == ST_OWNED && s_reg.line.sda_oe)
    else $error("Start not completed after second expiry.");
  start_bcol_a: assert property (s_reg.state == ST_START_WAIT && !scl_hi |=> // RULE5
    s_reg.status[`ST_BCOL_BIT] && s_reg.state == ST_IDLE && !s_reg.line.sda_oe)
    else $error("Start collision not flagged.");
  stop_release_a: assert property (s_reg.state == ST_STOP_PREP && expired && !sda_hi |=> // RULE6
    !s_reg.line.scl_oe && s_reg.line.sda_oe)
    else $error("SCL not released in Stop.");
  stop_stretch_a: assert property (s_reg.state == ST_STOP_SCL_WAIT && !scl_hi |=> // RULE7
    s_reg.state == ST_STOP_SCL_WAIT && $stable(s_reg.cnt))
    else $error("Stop did not wait for SCL high.");
  stop_case1_a: assert property (s_reg.state == ST_STOP_SDA_CHK && expired && !sda_hi |=> // RULE8
    s_reg.status[`ST_BCOL_BIT] && s_reg.state == ST_IDLE && s_reg.line == '0) // RULE10
    else $error("Stop collision case one missed.");
  stop_case2_a: assert property (s_reg.state == ST_STOP_SCL_HIGH && !scl_hi |=> // RULE9
    s_reg.status[`ST_BCOL_BIT] && s_reg.line == '0)
    else $error("Stop collision case two missed.");
  buf_write_collision_flag_a: assert property (i_req.wr && i_req.addr == `ADDR_BUFFER && busy |=> // RULE11
    s_reg.status[`ST_WRITE_COLLISION_FLAG_BIT] && $stable(s_reg.buffer))
    else $error("Busy buffer write not refused.");
  ctrl_lock_a: assert property (i_req.wr && i_req.addr == `ADDR_SEQ_CTRL && // RULE12
    s_reg.ctrl[`CTRL_START_BIT] |=> s_reg.ctrl[4:1] == $past(s_reg.ctrl[4:1]))
    else $error("Control write taken during Start.");

  // Stop steps; the Stop progress checks below hang off them.
  sequence stop_armed_s;
    s_reg.state == ST_OWNED && s_reg.ctrl[`CTRL_STOP_BIT];
  endsequence

  sequence scl_back_s;
    s_reg.state == ST_STOP_SCL_WAIT && scl_hi;
  endsequence

  sequence sda_free_s;
    s_reg.state == ST_STOP_SCL_HIGH && scl_hi && expired;
  endsequence

  sequence sda_check_s;
    s_reg.state == ST_STOP_SDA_CHK && expired;
  endsequence

  idle_bcol_a: assert property (start_blocked_s |=> // RULE5
    s_reg.status[`ST_BCOL_BIT] && !s_reg.ctrl[`CTRL_START_BIT] && s_reg.state == ST_IDLE)
    else $error("Start on a low bus not refused.");
  hold_keep_a: assert property (s_reg.state == ST_START_HOLD |=> s_reg.line.sda_oe) // RULE4
    else $error("SDA let go before the Start completed.");
  stop_enter_a: assert property (stop_armed_s |=> // RULE6
    s_reg.state == ST_STOP_PREP && s_reg.line.sda_oe && s_reg.cnt == $past(s_reg.reload))
    else $error("Stop did not begin with SDA low.");
  stop_load_a: assert property (scl_back_s |=> // RULE7
    s_reg.state == ST_STOP_SCL_HIGH && s_reg.cnt == $past(s_reg.reload))
    else $error("Baud counter not loaded once SCL was high.");
  stop_free_a: assert property (sda_free_s |=> // RULE8
    s_reg.state == ST_STOP_SDA_CHK && !s_reg.line.sda_oe && s_reg.cnt == $past(s_reg.reload))
    else $error("SDA not released after the baud period.");
  stop_end_a: assert property (sda_check_s |=> // RULE10
    s_reg.state == ST_IDLE && s_reg.line == '0)
    else $error("Stop did not return to idle.");

  // The interrupt follows the enabled status one cycle late.
  irq_set_a: assert property ((|(s_reg.status & s_reg.int_en)) |=> s_reg.irq)
    else $error("Interrupt not raised for an enabled flag.");
  irq_clear_a: assert property (!(|(s_reg.status & s_reg.int_en)) |=> !s_reg.irq)
    else $error("Interrupt raised with no enabled flag.");

  // A synchronised level moves only once stages two and three agree on it.
  sda_level_a: assert property ($changed(s_reg.sda_lv) |->
    $past(s_reg.sda_sync[1]) == s_reg.sda_lv && $past(s_reg.sda_sync[2]) == s_reg.sda_lv)
    else $error("SDA level taken before the synchroniser settled.");
  scl_level_a: assert property ($changed(s_reg.scl_lv) |->
    $past(s_reg.scl_sync[1]) == s_reg.scl_lv && $past(s_reg.scl_sync[2]) == s_reg.scl_lv)
    else $error("SCL level taken before the synchroniser settled.");

endmodule

`default_nettype wire

// [include/i2c_ssc_defs.svh]
// Register map, field positions and reset values for the I2C start/stop collision engine.
// Assumes inclusion by bare name from the package and from the engine module.
//
// What this block does
// RULE1 - Setting start_enable in sequence_control_reg starts a Start sequence.
// RULE2 - Both lines high at Start: load baud_counter from baud_reload_value and count.
// RULE3 - Both still high at expiry: drive SDA low, set start-detected flag.
// RULE4 - Reload, count again; next expiry clears start_enable, holds SDA low.
// RULE5 - Both low at Start, or SCL low early: bus_collision_flag, abort, idle.
// RULE6 - Stop begins with SDA low; once the baud counter expires with SDA sampled low, SCL is released.
// RULE7 - Wait for SCL high, stretching honoured, then load and count baud_counter.
// RULE8 - After SDA release and expiry, SDA sampled low flags bus collision.
// RULE9 - SCL sampled low after it went high but before SDA released during Stop flags bus collision.
// RULE10 - Stop collision sets flag, releases both lines, returns to idle.
// RULE11 - transfer_buffer write during any sequence is dropped, sets write_collision_flag.
// RULE12 - Lower five sequence control bits ignore writes until Start completes.
`ifndef I2C_SSC_DEFS_SVH
`define I2C_SSC_DEFS_SVH

`define ADDR_SEQ_CTRL   8'h00
`define ADDR_BAUD       8'h04
`define ADDR_STATUS     8'h08
`define ADDR_CLEAR      8'h0C
`define ADDR_INT_EN     8'h10
`define ADDR_BUFFER     8'h14
`define ADDR_PORT_STAT  8'h18

`define CTRL_START_BIT  0
`define CTRL_STOP_BIT   1
`define CTRL_SEQ_W      5

`define ST_START_BIT    0
`define ST_BCOL_BIT     1
`define ST_WRITE_COLLISION_FLAG_BIT     2
`define ST_STOP_BIT     3
`define ST_W            4

`define BAUD_RESET      8'h09
`define CTRL_RESET      5'h00
`define ST_RESET        4'h0

`endif

// [include/i2c_ssc_pkg.sv]
// Types for the I2C start/stop collision engine.
// Assumes i2c_ssc_defs.svh is on the include path.
`include "i2c_ssc_defs.svh"

package i2c_ssc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_WAIT,
    ST_START_HOLD,
    ST_OWNED,
    ST_STOP_PREP,
    ST_STOP_SCL_WAIT,
    ST_STOP_SCL_HIGH,
    ST_STOP_SDA_CHK
  } seq_state_t;

  typedef struct packed {
    logic sda_oe;
    logic scl_oe;
    logic sda_o;
    logic scl_o;
  } line_out_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0]            sda_sync;
    logic [2:0]            scl_sync;
    logic                  sda_lv;
    logic                  scl_lv;
    seq_state_t            state;
    logic [7:0]            cnt;
    logic [7:0]            reload;
    logic [`CTRL_SEQ_W-1:0] ctrl;
    logic [`ST_W-1:0]      status;
    logic [`ST_W-1:0]      int_en;
    logic [7:0]            buffer;
    logic                  start_bit;
    logic [7:0]            rdata;
    logic                  irq;
    line_out_t             line;
  } engine_t;

endpackage

// [dv/i2c_bus_peer.sv]
// Other party on the shared bus: pulls SDA or SCL low on command, resolves both wires.
// Assumes pull-ups on both wires and the engine's open-drain enables.
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_peer
  import i2c_ssc_pkg::*;
(
  input  wire logic      i_sda_low,
  input  wire logic      i_scl_low,
  input  wire line_out_t i_line,
  output var  logic      o_sda,
  output var  logic      o_scl
);
  // Wired-AND: any party pulling low wins, otherwise the pull-up gives high.
  always_comb begin
    o_sda = ~(i_line.sda_oe | i_sda_low);
    o_scl = ~(i_line.scl_oe | i_scl_low);
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the Start/Stop collision engine.
// Assumes the engine and the bus peer; SCL stretching lasts 4 link periods of 160 ns.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ssc_defs.svh"
module testbench
  import i2c_ssc_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  reg_req_t   req = '0;
  logic [7:0] rdata;
  line_out_t  line;
  logic       irq;
  logic       sda;
  logic       scl;
  logic       sda_low = 1'b0;
  logic       scl_low = 1'b0;
  int         err_total = 0;
  int         n_tests = 0;

  i2c_ssc i_dut (.i_mclk(mclk), .i_rst(rst), .i_req(req), .o_rdata(rdata),
    .i_sda(sda), .i_scl(scl), .o_line(line), .o_irq(irq));
  i2c_bus_peer i_peer (.i_sda_low(sda_low), .i_scl_low(scl_low), .i_line(line),
    .o_sda(sda), .o_scl(scl));

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 chk(rdata, exp);
    @(posedge mclk);
  endtask

  // Bounded wait until the masked line enables match; n returns the cycles taken.
  task automatic wline(input logic [3:0] m, input logic [3:0] v, output int n);
    for (n = 0; n < 500 && (4'(line) & m) !== v; n++) @(posedge mclk);
    if (n == 500) chk(8'h00, 8'hFF);
  endtask

  task automatic own_bus();
    int n;
    wr(`ADDR_SEQ_CTRL, 8'h01);
    wline(4'h8, 4'h8, n);
    repeat (40) @(posedge mclk);
    wr(`ADDR_CLEAR, 8'hFF);
    wr(`ADDR_SEQ_CTRL, 8'h02);
    wline(4'h4, 4'h4, n);
    wline(4'h4, 4'h0, n);
  endtask

  task automatic t_reset();
    rchk(`ADDR_BAUD, 8'h09);
    rchk(`ADDR_STATUS, 8'h00);
    rchk(`ADDR_SEQ_CTRL, 8'h00);
    rchk(8'h1C, 8'h00);
    rchk(`ADDR_PORT_STAT, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_BAUD, 8'h20);
    rchk(`ADDR_BAUD, 8'h20);
    wr(`ADDR_INT_EN, 8'h01);
    rchk(`ADDR_INT_EN, 8'h01);
  endtask

  task automatic t_start();
    int n;
    wr(`ADDR_BUFFER, 8'h33);
    wr(`ADDR_SEQ_CTRL, 8'h01);
    wline(4'h8, 4'h8, n);
    chk(8'(n >= 32 && n <= 36), 8'h01);
    rchk(`ADDR_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(`ADDR_BUFFER, 8'h5A);
    wr(`ADDR_SEQ_CTRL, 8'h1E);
    rchk(`ADDR_PORT_STAT, 8'h0E);
    repeat (40) @(posedge mclk);
    rchk(`ADDR_SEQ_CTRL, 8'h00);
    rchk(`ADDR_BUFFER, 8'h33);
    rchk(`ADDR_STATUS, 8'h05);
    chk(8'(line), 8'h08);
    rchk(`ADDR_PORT_STAT, 8'h06);
    wr(`ADDR_CLEAR, 8'hFF);
    rchk(`ADDR_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_stop();
    int n;
    scl_low <= 1'b1;
    wr(`ADDR_SEQ_CTRL, 8'h02);
    wline(4'h4, 4'h4, n);
    wline(4'h4, 4'h0, n);
    chk(8'(line), 8'h08);
    repeat (32) @(posedge mclk);
    chk(8'(line), 8'h08);
    scl_low <= 1'b0;
    wline(4'hC, 4'h0, n);
    chk(8'(n >= 33), 8'h01);
    repeat (40) @(posedge mclk);
    rchk(`ADDR_STATUS, 8'h08);
    wr(`ADDR_CLEAR, 8'hFF);
  endtask

  task automatic t_bcol_both();
    sda_low <= 1'b1;
    scl_low <= 1'b1;
    repeat (5) @(posedge mclk);
    wr(`ADDR_SEQ_CTRL, 8'h01);
    repeat (8) @(posedge mclk);
    rchk(`ADDR_STATUS, 8'h02);
    rchk(`ADDR_SEQ_CTRL, 8'h00);
    chk(8'(line), 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`ADDR_INT_EN, 8'h03);
    @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    sda_low <= 1'b0;
    scl_low <= 1'b0;
    wr(`ADDR_INT_EN, 8'h01);
    wr(`ADDR_CLEAR, 8'hFF);
  endtask

  task automatic t_bcol_scl();
    wr(`ADDR_SEQ_CTRL, 8'h01);
    repeat (6) @(posedge mclk);
    scl_low <= 1'b1;
    repeat (8) @(posedge mclk);
    rchk(`ADDR_STATUS, 8'h02);
    chk(8'(line), 8'h00);
    scl_low <= 1'b0;
    wr(`ADDR_CLEAR, 8'hFF);
  endtask

  task automatic t_scol_sda();
    int n;
    own_bus();
    wline(4'h8, 4'h0, n);
    sda_low <= 1'b1;
    repeat (40) @(posedge mclk);
    rchk(`ADDR_STATUS, 8'h02);
    rchk(`ADDR_SEQ_CTRL, 8'h00);
    chk(8'(line), 8'h00);
    sda_low <= 1'b0;
    wr(`ADDR_CLEAR, 8'hFF);
  endtask

  task automatic t_scol_scl();
    own_bus();
    repeat (10) @(posedge mclk);
    scl_low <= 1'b1;
    repeat (8) @(posedge mclk);
    rchk(`ADDR_STATUS, 8'h02);
    chk(8'(line), 8'h00);
    scl_low <= 1'b0;
    wr(`ADDR_CLEAR, 8'hFF);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_start();
    t_stop();
    t_bcol_both();
    t_bcol_scl();
    t_scol_sda();
    t_scol_scl();
    final_report();
  end
endmodule
`default_nettype wire
